/* design/wdg_edge_sync.sv */
// three-stage synchroniser with agreement filter and rising-edge pulse
module wdg_edge_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      rise_o
);
  logic [2:0] stage;
  logic       level;
  logic [2:0] next_stage;
  logic       next_level;
  logic       next_rise;

  // first stage feeds only the second; stages two and three must agree
  always_comb
  begin
    next_stage = {stage[1:0], async_i};
    next_level = level;
    next_rise  = 1'b0;
    if (stage[1] == stage[2])
    begin
      next_level = stage[2];
      next_rise  = stage[2] & ~level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      stage  <= 3'h0;
      level  <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      stage  <= next_stage;
      level  <= next_level;
      rise_o <= next_rise;
    end
  end
endmodule

/* design/wdg_pkg.sv */
// shared constants and types for the windowed watchdog back end
package wdg_pkg;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned PER_W = 15;

  // time-out period in count cycles, per timeout_select code
  localparam logic [PER_W-1:0] PERIOD_SEL0 = 15'h0400;
  localparam logic [PER_W-1:0] PERIOD_SEL1 = 15'h1000;
  localparam logic [PER_W-1:0] PERIOD_SEL2 = 15'h2000;
  localparam logic [PER_W-1:0] PERIOD_SEL3 = 15'h4000;

  // prescale divisors, per prescale_select code
  localparam logic [3:0] PRESCALE_CODE_DIV16  = 4'h2;
  localparam logic [3:0] PRESCALE_CODE_DIV32  = 4'h3;
  localparam logic [3:0] PRESCALE_CODE_DIV64  = 4'h4;
  localparam logic [3:0] PRESCALE_CODE_DIV256 = 4'h5;
  localparam logic [3:0] PRESCALE_CODE_DIV128 = 4'hf;
  localparam logic [8:0] DIV_1   = 9'h001;
  localparam logic [8:0] DIV_16  = 9'h010;
  localparam logic [8:0] DIV_32  = 9'h020;
  localparam logic [8:0] DIV_64  = 9'h040;
  localparam logic [8:0] DIV_128 = 9'h080;
  localparam logic [8:0] DIV_256 = 9'h100;

  // refresh key sequence
  localparam logic [7:0] KEY_ARM  = 8'h00;
  localparam logic [7:0] KEY_FIRE = 8'hff;

  // reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
  localparam logic [1:0]       SEL_RESET = 2'h3;
  localparam logic [3:0]       CKS_RESET = 4'hf;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_HALT = 3'b010,
    ST_RUN  = 3'b100
  } wdg_state_t;
endpackage

/* design/wdg_top.sv */
// windowed watchdog: count, refresh window, reset/nmi output, snapshot
module wdg_top (
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      RST_N_I,
  input  wire logic                      WATCHDOG_DEDICATED_CLOCK_I,
  input  wire logic                      SLEEP_I,
  input  wire logic                      OPT_START_MODE_SELECT_I,
  input  wire logic [1:0]                OPT_TIMEOUT_SELECT_I,
  input  wire logic [3:0]                OPT_PRESCALE_SELECT_I,
  input  wire logic [1:0]                OPT_WINDOW_START_SELECT_I,
  input  wire logic [1:0]                OPT_WINDOW_END_SELECT_I,
  input  wire logic                      OPTION_RESET_OR_IRQ_SELECT_I,
  input  wire logic                      OPT_SLEEP_COUNT_STOP_I,
  input  wire logic                      CFG_WR_I,
  input  wire logic [1:0]                CFG_TIMEOUT_SELECT_I,
  input  wire logic [3:0]                CFG_PRESCALE_SELECT_I,
  input  wire logic [1:0]                CFG_WINDOW_START_SELECT_I,
  input  wire logic [1:0]                CFG_WINDOW_END_SELECT_I,
  input  wire logic                      CFG_RESET_OR_IRQ_SELECT_I,
  input  wire logic                      CFG_SLEEP_COUNT_STOP_I,
  input  wire logic                      REFRESH_KEY_WR_I,
  input  wire logic [7:0]                REFRESH_KEY_DATA_I,
  input  wire logic                      STATUS_WR_I,
  input  wire logic                      STATUS_UNDERFLOW_WDATA_I,
  input  wire logic                      STATUS_REFRESH_ERROR_WDATA_I,
  output logic                           WDG_RESET_O,
  output logic                           WATCHDOG_NMI_REQUEST_O,
  output logic [wdg_pkg::CNT_W-1:0]      COUNTER_SNAPSHOT_O,
  output logic                           UNDERFLOW_FLAG_O,
  output logic                           REFRESH_ERROR_FLAG_O,
  output logic                           COUNTING_O,
  output logic                           CFG_LOCKED_O
);
  localparam int unsigned W = wdg_pkg::CNT_W;
  localparam int unsigned P = wdg_pkg::PER_W;

  wdg_pkg::wdg_state_t state, next_state;
  logic         reg_mode, next_reg_mode;
  logic [1:0]   r_timeout_select, next_r_timeout_select;
  logic [3:0]   r_cks, next_r_cks;
  logic [1:0]   r_window_start_select, next_r_window_start_select;
  logic [1:0]   r_window_end_select, next_r_window_end_select;
  logic         r_rirq, next_r_rirq;
  logic         r_slst, next_r_slst;
  logic         locked, next_locked;
  logic [W-1:0] cnt, next_cnt;
  logic [8:0]   div_cnt, next_div_cnt;
  logic         armed, next_armed;
  logic         rst_out, next_rst_out, nmi, next_nmi;
  logic         uf_flag, next_uf_flag;
  logic         re_flag, next_re_flag;
  logic [W-1:0] snap1, snap2, snap3;
  logic         wclk_rise;

  // effective settings and derived values
  logic [1:0]   e_timeout_select, e_window_start_select, e_window_end_select;
  logic [3:0]   e_cks;
  logic [P-1:0] period, quarter, win_start, win_end;
  logic [8:0]   divisor;
  logic         e_rirq, e_slst, tick, refresh, in_window, underflow, ref_err, event_hit;

  wdg_edge_sync u_wclk_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .async_i (WATCHDOG_DEDICATED_CLOCK_I),
    .rise_o  (wclk_rise)
  );

  // configuration source follows the start mode captured at release
  always_comb
  begin
    e_timeout_select  = reg_mode ? r_timeout_select : OPT_TIMEOUT_SELECT_I;
    e_cks   = reg_mode ? r_cks  : OPT_PRESCALE_SELECT_I;
    e_window_start_select  = reg_mode ? r_window_start_select : OPT_WINDOW_START_SELECT_I;
    e_window_end_select  = reg_mode ? r_window_end_select : OPT_WINDOW_END_SELECT_I;
    e_rirq  = reg_mode ? r_rirq : OPTION_RESET_OR_IRQ_SELECT_I;
    e_slst  = reg_mode ? r_slst : OPT_SLEEP_COUNT_STOP_I;
    case (e_timeout_select)
      2'h0:    period = wdg_pkg::PERIOD_SEL0;
      2'h1:    period = wdg_pkg::PERIOD_SEL1;
      2'h2:    period = wdg_pkg::PERIOD_SEL2;
      default: period = wdg_pkg::PERIOD_SEL3;
    endcase
    case (e_cks)
      wdg_pkg::PRESCALE_CODE_DIV16:  divisor = wdg_pkg::DIV_16;
      wdg_pkg::PRESCALE_CODE_DIV32:  divisor = wdg_pkg::DIV_32;
      wdg_pkg::PRESCALE_CODE_DIV64:  divisor = wdg_pkg::DIV_64;
      wdg_pkg::PRESCALE_CODE_DIV128: divisor = wdg_pkg::DIV_128;
      wdg_pkg::PRESCALE_CODE_DIV256: divisor = wdg_pkg::DIV_256;
      default:                       divisor = wdg_pkg::DIV_1;
    endcase
    // window start opens at (k+1)/4 of the period, end closes at (3-k)/4
    quarter   = period >> 2;
    win_start = P'(quarter * P'({1'b0, e_window_start_select} + 3'h1)) - P'(1);
    win_end   = P'(quarter * P'(3'h3 - {1'b0, e_window_end_select}));
    in_window = ({1'b0, cnt} <= win_start) && ({1'b0, cnt} >= win_end);
  end

  // main next-state logic
  always_comb
  begin
    next_state    = state;
    next_reg_mode = reg_mode;
    next_r_timeout_select   = r_timeout_select;
    next_r_cks    = r_cks;
    next_r_window_start_select   = r_window_start_select;
    next_r_window_end_select   = r_window_end_select;
    next_r_rirq   = r_rirq;
    next_r_slst   = r_slst;
    next_locked   = locked;
    next_cnt      = cnt;
    next_div_cnt  = div_cnt;
    next_armed    = armed;
    next_uf_flag  = uf_flag;
    next_re_flag  = re_flag;
    refresh       = 1'b0;

    // count cycle: prescaled watchdog clock edges; sleep may freeze it
    tick = 1'b0;
    if (wclk_rise && !(SLEEP_I && e_slst))
    begin
      tick         = (div_cnt >= divisor - 9'h001);
      next_div_cnt = tick ? 9'h000 : div_cnt + 9'h001;
    end

    // key sequence; reads or other writes between keys do not disturb it
    if (REFRESH_KEY_WR_I && state != wdg_pkg::ST_BOOT)
    begin
      next_armed = (REFRESH_KEY_DATA_I == wdg_pkg::KEY_ARM);
      refresh    = armed && (REFRESH_KEY_DATA_I == wdg_pkg::KEY_FIRE);
    end

    underflow = (state == wdg_pkg::ST_RUN) && tick && (cnt == '0);
    ref_err   = (state == wdg_pkg::ST_RUN) && refresh && !in_window;
    event_hit = underflow || ref_err;

    // one-time configuration writes, locked by a write or first refresh
    if (CFG_WR_I && !locked && reg_mode)
    begin
      next_r_timeout_select = CFG_TIMEOUT_SELECT_I;
      next_r_cks  = CFG_PRESCALE_SELECT_I;
      next_r_window_start_select = CFG_WINDOW_START_SELECT_I;
      next_r_window_end_select = CFG_WINDOW_END_SELECT_I;
      next_r_rirq = CFG_RESET_OR_IRQ_SELECT_I;
      next_r_slst = CFG_SLEEP_COUNT_STOP_I;
      next_locked = 1'b1;
    end

    case (state)
      wdg_pkg::ST_BOOT:
      begin
        next_reg_mode = OPT_START_MODE_SELECT_I;
        next_div_cnt  = 9'h000;
        if (OPT_START_MODE_SELECT_I)
        begin
          next_state = wdg_pkg::ST_HALT;
        end
        else
        begin
          next_cnt   = W'(period - P'(1));        // option word period
          next_state = wdg_pkg::ST_RUN;
        end
      end
      wdg_pkg::ST_HALT:
      begin
        if (refresh)
        begin
          next_cnt    = W'(period - P'(1));
          next_locked = 1'b1;
          next_state  = wdg_pkg::ST_RUN;
        end
      end
      wdg_pkg::ST_RUN:
      begin
        if (event_hit && reg_mode)
        begin
          next_cnt   = wdg_pkg::CNT_RESET;
          next_state = wdg_pkg::ST_HALT;
        end
        else if (event_hit || refresh)
        begin
          next_cnt = W'(period - P'(1));
        end
        else if (tick)
        begin
          next_cnt = cnt - W'(1);
        end
      end
      default:
      begin
        next_state = wdg_pkg::ST_BOOT;
      end
    endcase

    // reset output lasts until the next count cycle boundary
    next_rst_out = (event_hit && e_rirq) || (rst_out && !tick);
    // nmi only goes to the nmi controller; no transfer trigger exists
    next_nmi = event_hit && !e_rirq;

    // status flags: new event overwrites, set beats a same-cycle clear
    if (underflow)
    begin
      next_uf_flag = 1'b1;
      next_re_flag = 1'b0;
    end
    else if (ref_err)
    begin
      next_re_flag = 1'b1;
      next_uf_flag = 1'b0;
    end
    else if (STATUS_WR_I)
    begin
      next_uf_flag = uf_flag & STATUS_UNDERFLOW_WDATA_I;
      next_re_flag = re_flag & STATUS_REFRESH_ERROR_WDATA_I;
    end
  end

  // main state registers
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state    <= wdg_pkg::ST_BOOT;
      reg_mode <= 1'b0;
      r_timeout_select   <= wdg_pkg::SEL_RESET;
      r_cks    <= wdg_pkg::CKS_RESET;
      r_window_start_select   <= wdg_pkg::SEL_RESET;
      r_window_end_select   <= wdg_pkg::SEL_RESET;
      r_rirq   <= 1'b1;
      r_slst   <= 1'b1;
      locked   <= 1'b0;
      cnt      <= wdg_pkg::CNT_RESET;
      div_cnt  <= 9'h000;
      armed    <= 1'b0;
      rst_out  <= 1'b0;
      nmi      <= 1'b0;
      uf_flag  <= 1'b0;
      re_flag  <= 1'b0;
      COUNTING_O         <= 1'b0;
      snap1              <= wdg_pkg::CNT_RESET;
      snap2              <= wdg_pkg::CNT_RESET;
      snap3              <= wdg_pkg::CNT_RESET;
      COUNTER_SNAPSHOT_O <= wdg_pkg::CNT_RESET;
    end
    else
    begin
      state    <= next_state;
      reg_mode <= next_reg_mode;
      r_timeout_select   <= next_r_timeout_select;
      r_cks    <= next_r_cks;
      r_window_start_select   <= next_r_window_start_select;
      r_window_end_select   <= next_r_window_end_select;
      r_rirq   <= next_r_rirq;
      r_slst   <= next_r_slst;
      locked   <= next_locked;
      cnt      <= next_cnt;
      div_cnt  <= next_div_cnt;
      armed    <= next_armed;
      rst_out  <= next_rst_out;
      nmi      <= next_nmi;
      uf_flag  <= next_uf_flag;
      re_flag  <= next_re_flag;
      COUNTING_O         <= (next_state == wdg_pkg::ST_RUN);
      snap1              <= cnt;
      snap2              <= snap1;
      snap3              <= snap2;
      COUNTER_SNAPSHOT_O <= snap3;   // four stages keep the view within four cycles
    end
  end

  // outputs are the state flops themselves; a second copy would only double the area
  assign WDG_RESET_O            = rst_out;
  assign WATCHDOG_NMI_REQUEST_O = nmi;
  assign UNDERFLOW_FLAG_O       = uf_flag;
  assign REFRESH_ERROR_FLAG_O   = re_flag;
  assign CFG_LOCKED_O           = locked;
endmodule

/* testbench/independent_watchdog_output_tb.sv */
// self-checking bench for the windowed watchdog back end
module independent_watchdog_output_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK_I = 1'b0, RST_N_I = 1'b0, WATCHDOG_DEDICATED_CLOCK_I = 1'b0, SLEEP_I = 1'b0;
  logic OPT_START_MODE_SELECT_I = 1'b0, OPTION_RESET_OR_IRQ_SELECT_I = 1'b1;
  logic OPT_SLEEP_COUNT_STOP_I = 1'b0, CFG_WR_I = 1'b0, CFG_RESET_OR_IRQ_SELECT_I = 1'b0;
  logic CFG_SLEEP_COUNT_STOP_I = 1'b0, REFRESH_KEY_WR_I = 1'b0, STATUS_WR_I = 1'b0;
  logic STATUS_UNDERFLOW_WDATA_I = 1'b1, STATUS_REFRESH_ERROR_WDATA_I = 1'b1;
  logic [1:0] OPT_TIMEOUT_SELECT_I = 2'h0, OPT_WINDOW_START_SELECT_I = 2'h3;
  logic [1:0] OPT_WINDOW_END_SELECT_I = 2'h3, CFG_TIMEOUT_SELECT_I = 2'h0;
  logic [1:0] CFG_WINDOW_START_SELECT_I = 2'h3, CFG_WINDOW_END_SELECT_I = 2'h3;
  logic [3:0] OPT_PRESCALE_SELECT_I = 4'h0, CFG_PRESCALE_SELECT_I = 4'h0;
  logic [7:0] REFRESH_KEY_DATA_I = 8'h00;
  logic       WDG_RESET_O, WATCHDOG_NMI_REQUEST_O, UNDERFLOW_FLAG_O;
  logic       REFRESH_ERROR_FLAG_O, COUNTING_O, CFG_LOCKED_O, rst_d, nmi_d;
  logic [wdg_pkg::CNT_W-1:0] COUNTER_SNAPSHOT_O, snap;
  logic [1:0]  exp_q[$];
  logic [31:0] rng = 32'h58acdec1;
  int          fail_count = 0, checked = 0, rst_seen, nmi_seen;

  wdg_top dut (.*);
  wdg_sys_model sys (.clk_i(CORE_CLK_I), .reset_req_i(WDG_RESET_O),
    .nmi_req_i(WATCHDOG_NMI_REQUEST_O), .reset_count_o(rst_seen), .nmi_count_o(nmi_seen));

  initial forever #2 CORE_CLK_I = ~CORE_CLK_I;
  // 40 ns watchdog clock, offset so its edges never meet the core edge
  initial
  begin
    #1.3;
    forever #20 WATCHDOG_DEDICATED_CLOCK_I = ~WATCHDOG_DEDICATED_CLOCK_I;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick;
    @(posedge CORE_CLK_I);
    #1;
  endtask

  // option word only changes under reset, never while counting
  task automatic restart(input logic mode);
    RST_N_I = 1'b0;
    OPT_START_MODE_SELECT_I = mode;
    rng = xs(rng);
    OPT_WINDOW_START_SELECT_I = rng[1:0];
    OPT_WINDOW_END_SELECT_I = rng[3:2];
    OPT_SLEEP_COUNT_STOP_I = rng[4];
    repeat (16) tick;
    RST_N_I = 1'b1;
    repeat (2) tick;
  endtask

  task automatic key(input logic [7:0] v);
    REFRESH_KEY_WR_I = 1'b1;
    REFRESH_KEY_DATA_I = v;
    tick;
    REFRESH_KEY_WR_I = 1'b0;
    tick;
  endtask

  task automatic cfg(input logic sel, input logic [1:0] ws, input logic [3:0] ck, input logic st);
    CFG_WR_I = 1'b1;
    CFG_RESET_OR_IRQ_SELECT_I = sel;
    CFG_WINDOW_START_SELECT_I = ws;
    CFG_PRESCALE_SELECT_I = ck;
    CFG_SLEEP_COUNT_STOP_I = st;
    tick;
    CFG_WR_I = 1'b0;
    tick;
  endtask

  task automatic status(input logic v);
    STATUS_WR_I = 1'b1;
    STATUS_UNDERFLOW_WDATA_I = v;
    STATUS_REFRESH_ERROR_WDATA_I = v;
    tick;
    STATUS_WR_I = 1'b0;
    tick;
  endtask

  // waits until the monitor has retired every queued event, bounded
  task automatic wait_ev(input int lim);
    int n = 0;
    while (exp_q.size() > 0 && n < lim)
    begin
      tick;
      n++;
    end
    if (exp_q.size() > 0)
    begin
      fail_count++;
      $display("MISMATCH t=%0t expected event missing", $time);
      tally_and_finish;
    end
  endtask

  // a rising reset or nmi retires the oldest expected event
  always @(posedge CORE_CLK_I)
  begin
    rst_d <= WDG_RESET_O;
    nmi_d <= WATCHDOG_NMI_REQUEST_O;
    if ((WDG_RESET_O & ~rst_d) === 1'b1 || (WATCHDOG_NMI_REQUEST_O & ~nmi_d) === 1'b1)
    begin
      if (exp_q.size() == 0)
        check({14'h0, WATCHDOG_NMI_REQUEST_O, WDG_RESET_O}, 16'h0);
      else
        check({14'h0, WATCHDOG_NMI_REQUEST_O, WDG_RESET_O}, {14'h0, exp_q.pop_front()});
    end
  end

  initial
  begin
    restart(1'b0);
    tick;
    check(COUNTING_O, 1'b1);
    cfg(1'b0, 2'h0, 4'h0, 1'b0);
    check(CFG_LOCKED_O, 1'b0);
    repeat (100) tick;
    check(COUNTER_SNAPSHOT_O < 14'h0400 && COUNTER_SNAPSHOT_O > 14'h03d0, 1'b1);
    exp_q.push_back(2'b01);
    wait_ev(12000);
    repeat (40) tick;
    check({UNDERFLOW_FLAG_O, REFRESH_ERROR_FLAG_O, COUNTING_O}, 3'b101);
    check(rst_seen[15:0], 16'h1);
    status(1'b1);
    check(UNDERFLOW_FLAG_O, 1'b1);
    status(1'b0);
    check(UNDERFLOW_FLAG_O, 1'b0);
    $display("test auto start done");
    restart(1'b1);
    check(COUNTING_O, 1'b0);
    // full window leaves margin for both clock tolerances
    cfg(1'b0, 2'h3, 4'h0, 1'b1);
    check(CFG_LOCKED_O, 1'b1);
    rng = xs(rng);
    key(8'h00);
    key((rng[7:0] == 8'h00 || rng[7:0] == 8'hff) ? 8'h5a : rng[7:0]);
    key(8'hff);
    check(COUNTING_O, 1'b0);
    key(8'h00);
    key(8'hff);
    check(COUNTING_O, 1'b1);
    SLEEP_I = 1'b1;
    repeat (20) tick;
    snap = COUNTER_SNAPSHOT_O;
    repeat (200) tick;
    check(COUNTER_SNAPSHOT_O, snap);
    SLEEP_I = 1'b0;
    exp_q.push_back(2'b10);
    wait_ev(12000);
    repeat (8) tick;
    check({COUNTING_O, COUNTER_SNAPSHOT_O}, 15'h0);
    check(nmi_seen[15:0], 16'h1);
    $display("test register start nmi done");
    restart(1'b1);
    cfg(1'b1, 2'h0, 4'h2, 1'b0);
    key(8'h00);
    key(8'hff);
    check(COUNTING_O, 1'b1);
    // counter sits far above the quarter window: this refresh is early
    exp_q.push_back(2'b01);
    key(8'h00);
    key(8'hff);
    wait_ev(20);
    repeat (200) tick;
    check({UNDERFLOW_FLAG_O, REFRESH_ERROR_FLAG_O, COUNTING_O, WDG_RESET_O}, 4'b0100);
    key(8'h00);
    key(8'hff);
    check(COUNTING_O, 1'b1);
    $display("test refresh error done");
    tally_and_finish;
  end
endmodule

/* testbench/wdg_props.sv */
// checker for the watchdog reset/nmi outputs, refresh start and status flags
module wdg_props (
  input wire logic                      CORE_CLK_I,
  input wire logic                      RST_N_I,
  input wire logic                      OPT_START_MODE_SELECT_I,
  input wire logic                      REFRESH_KEY_WR_I,
  input wire logic [7:0]                REFRESH_KEY_DATA_I,
  input wire logic                      STATUS_WR_I,
  input wire logic                      STATUS_UNDERFLOW_WDATA_I,
  input wire logic                      WDG_RESET_O,
  input wire logic                      WATCHDOG_NMI_REQUEST_O,
  input wire logic [wdg_pkg::CNT_W-1:0] COUNTER_SNAPSHOT_O,
  input wire logic                      UNDERFLOW_FLAG_O,
  input wire logic                      REFRESH_ERROR_FLAG_O,
  input wire logic                      COUNTING_O,
  input wire logic                      CFG_LOCKED_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic armed;
  logic next_armed;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // tracks a pending 00h key; any other value disarms
  always_comb
  begin
    next_armed = armed;
    if (REFRESH_KEY_WR_I)
      next_armed = (REFRESH_KEY_DATA_I == 8'h00);
  end

  always_ff @(posedge CORE_CLK_I)
    armed <= RST_N_I ? next_armed : 1'b0;

  a_reset_len_bound: assert property ($rose(WDG_RESET_O) |-> ##[1:1000] !WDG_RESET_O)
    else $error("reset output held too long");
  a_nmi_single_pulse: assert property ($rose(WATCHDOG_NMI_REQUEST_O) |=> !WATCHDOG_NMI_REQUEST_O)
    else $error("nmi request longer than one cycle");
  a_out_exclusive: assert property (!(WDG_RESET_O && WATCHDOG_NMI_REQUEST_O))
    else $error("reset and nmi together");
  a_event_one_flag: assert property (($rose(WDG_RESET_O) || $rose(WATCHDOG_NMI_REQUEST_O))
    |-> (UNDERFLOW_FLAG_O ^ REFRESH_ERROR_FLAG_O))
    else $error("event without exactly one source flag");
  a_flag_clear_write: assert property (STATUS_WR_I && !STATUS_UNDERFLOW_WDATA_I |=> !UNDERFLOW_FLAG_O
    || $rose(WDG_RESET_O) || $rose(WATCHDOG_NMI_REQUEST_O))
    else $error("underflow flag not cleared");
  a_refresh_starts: assert property (REFRESH_KEY_WR_I && REFRESH_KEY_DATA_I == 8'hff && armed
    && !COUNTING_O |=> COUNTING_O)
    else $error("valid refresh did not start counting");
  a_halt_holds: assert property (OPT_START_MODE_SELECT_I && !COUNTING_O
    && !(REFRESH_KEY_WR_I && armed) |=> !COUNTING_O)
    else $error("halted counter started without refresh");
  a_halt_zero_count: assert property (OPT_START_MODE_SELECT_I && $fell(COUNTING_O)
    |-> ##6 (COUNTER_SNAPSHOT_O == 14'h0000) [*4])
    else $error("halted counter not zero");
  a_auto_keeps: assert property (!OPT_START_MODE_SELECT_I && COUNTING_O |=> COUNTING_O)
    else $error("auto-start counter stopped");
  a_auto_start_boot: assert property ($rose(RST_N_I) && !OPT_START_MODE_SELECT_I
    |-> ##[1:3] COUNTING_O)
    else $error("auto-start did not begin counting");
  a_lock_sticks: assert property (CFG_LOCKED_O |=> CFG_LOCKED_O)
    else $error("config lock dropped");

  c_reset_out: cover property ($rose(WDG_RESET_O));
  c_nmi_out: cover property ($rose(WATCHDOG_NMI_REQUEST_O));
  c_refresh_err: cover property ($rose(REFRESH_ERROR_FLAG_O));
endmodule

bind wdg_top wdg_props u_props (.*);

/* testbench/wdg_sys_model.sv */
// behavioural system reset generator and nmi controller facing the watchdog
module wdg_sys_model (
  input  wire logic clk_i,
  input  wire logic reset_req_i,
  input  wire logic nmi_req_i,
  output int        reset_count_o,
  output int        nmi_count_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic reset_d;

  // one system reset per rising request; the level lasts until the next count cycle boundary
  // nmi lands on the nmi input only, no transfer or copy trigger path
  always @(posedge clk_i)
  begin
    reset_d <= reset_req_i;
    if ((reset_req_i & ~reset_d) === 1'b1)
      reset_count_o <= reset_count_o + 1;
    if (nmi_req_i === 1'b1)
      nmi_count_o <= nmi_count_o + 1;
  end
endmodule
